// ---- rtl/sdrrs_refresh.v ----
// Purpose: Decodes refresh commands and tracks the single-bank refresh counter.
// Assumes: Command pins come from another clock domain and are synchronised here.
// Notes:   Controller-side obligations are listed but not policed by this logic.
//
// Contract
// - Refresh: select low, bit0/1 low, bit2 high
// - Bit3 low single-bank, high all-bank
// - Counter picks bank, advances 0..7, wraps
// - Reset command and self-refresh exit clear counter
// - All-bank refresh clears counter too
// - Refreshed bank busy; other banks usable
// - Bank idle when single-bank cycle completes
// - All-bank refresh leaves banks idle; wait cycle
`timescale 1ns/100ps
`default_nettype none
`include "sdrrs_defines.vh"

module sdrrs_refresh (
  input  wire       clock,
  input  wire       arst_n,
  input  wire       clk_en,
  input  wire       chip_select_n,
  input  wire       cmd_addr_bit0,
  input  wire       cmd_addr_bit1,
  input  wire       cmd_addr_bit2,
  input  wire       cmd_addr_bit3,
  input  wire       reset_cmd,
  input  wire       self_refresh_exit,
  output reg  [2:0] next_refresh_bank,
  output reg  [7:0] bank_busy,
  output reg        all_banks_busy,
  output reg        single_bank_refresh,
  output reg        all_bank_refresh,
  output reg  [2:0] refreshed_bank
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Stage one feeds only stage two to keep metastability out of decode.
  reg [6:0] sync_a;
  reg [6:0] sync_b;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 7'h01;
      sync_b <= 7'h01;
    end else if (clk_en) begin
      sync_a <= {self_refresh_exit, reset_cmd, cmd_addr_bit3, cmd_addr_bit2,
                 cmd_addr_bit1, cmd_addr_bit0, chip_select_n};
      sync_b <= sync_a;
    end
  end

  wire s_cs_n = sync_b[0];
  wire s_ca0  = sync_b[1];
  wire s_ca1  = sync_b[2];
  wire s_ca2  = sync_b[3];
  wire s_ca3  = sync_b[4];
  wire s_rst  = sync_b[5];
  wire s_srx  = sync_b[6];

  // ****************************************************************
  // Start-up guard
  // ****************************************************************
  // The first edge after reset only fills stage one (sync_a) with real
  // pin levels, so nothing is decoded until that edge has passed.
  reg started;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      started <= 1'b0;
    end else if (clk_en) begin
      started <= 1'b1;
    end
  end

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Shared by both refresh flavours so that they see one decode.
  function refresh_code;
    input cs_n;
    input ca0;
    input ca1;
    input ca2;
    begin
      refresh_code = !cs_n && !ca0 && !ca1 && ca2;
    end
  endfunction

  // Round-robin successor of a bank number; the last bank wraps to zero.
  function [`SDRRS_BANK_W-1:0] bank_after;
    input [`SDRRS_BANK_W-1:0] bank;
    begin
      if (bank == `SDRRS_BANK_LAST) begin
        bank_after = {`SDRRS_BANK_W{1'b0}};
      end else begin
        bank_after = bank + {{(`SDRRS_BANK_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire is_refresh  = refresh_code(s_cs_n, s_ca0, s_ca1, s_ca2);
  wire resync      = started && (s_rst || s_srx);

  // A resynchronising event wins over a refresh in the same cycle, so the
  // counter never steps away from the point the controller just reset.
  wire take_single = started && !resync && is_refresh && !s_ca3;
  wire take_all    = started && !resync && is_refresh && s_ca3;

  // ****************************************************************
  // Timer constants
  // ****************************************************************
  // The timers are five bits wide, so cycle times above 31 clocks would
  // need a wider timer; the load values are cut to width on purpose.
  localparam [31:0]                PB_CYCLES  = `SDRRS_SINGLE_BANK_REFRESH_CYCLE_TIME_CYC;
  localparam [31:0]                AB_CYCLES  = `SDRRS_ALL_BANK_REFRESH_CYCLE_TIME_CYC;
  localparam [`SDRRS_TIMER_W-1:0]  PB_LOAD    = PB_CYCLES[`SDRRS_TIMER_W-1:0];
  localparam [`SDRRS_TIMER_W-1:0]  AB_LOAD    = AB_CYCLES[`SDRRS_TIMER_W-1:0];
  localparam [`SDRRS_TIMER_W-1:0]  TIMER_ZERO = {`SDRRS_TIMER_W{1'b0}};
  localparam [`SDRRS_TIMER_W-1:0]  TIMER_ONE  = {{(`SDRRS_TIMER_W-1){1'b0}}, 1'b1};

  reg [`SDRRS_TIMER_W-1:0] bank_timer [0:`SDRRS_NUM_BANKS-1];
  reg [`SDRRS_TIMER_W-1:0] all_timer;
  integer                  i;

  // ****************************************************************
  // Refresh pulses
  // ****************************************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      single_bank_refresh <= 1'b0;
      all_bank_refresh    <= 1'b0;
    end else if (clk_en) begin
      single_bank_refresh <= take_single;
      all_bank_refresh    <= take_all;
    end
  end

  // ****************************************************************
  // Round-robin bank counter
  // ****************************************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      next_refresh_bank <= 3'h0;
      refreshed_bank    <= 3'h0;
    end else if (clk_en) begin
      if (resync) begin
        next_refresh_bank <= 3'h0;
      end else if (take_all) begin
        next_refresh_bank <= 3'h0;
      end else if (take_single) begin
        refreshed_bank    <= next_refresh_bank;
        next_refresh_bank <= bank_after(next_refresh_bank);
      end
    end
  end

  // ****************************************************************
  // Per-bank busy timers
  // ****************************************************************
  // Only the refreshed bank is marked; the others stay usable meanwhile.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_busy <= 8'h00;
      for (i = 0; i < `SDRRS_NUM_BANKS; i = i + 1) begin
        bank_timer[i] <= TIMER_ZERO;
      end
    end else if (clk_en) begin
      for (i = 0; i < `SDRRS_NUM_BANKS; i = i + 1) begin
        if (take_single && (next_refresh_bank == i[`SDRRS_BANK_W-1:0])) begin
          bank_timer[i] <= PB_LOAD;
          bank_busy[i]  <= 1'b1;
        end else begin
          if (bank_timer[i] != TIMER_ZERO) begin
            bank_timer[i] <= bank_timer[i] - TIMER_ONE;
          end
          bank_busy[i] <= (bank_timer[i] > TIMER_ONE);
        end
      end
    end
  end

  // ****************************************************************
  // All-bank busy timer
  // ****************************************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      all_banks_busy <= 1'b0;
      all_timer      <= TIMER_ZERO;
    end else if (clk_en) begin
      if (take_all) begin
        all_timer      <= AB_LOAD;
        all_banks_busy <= 1'b1;
      end else begin
        if (all_timer != TIMER_ZERO) begin
          all_timer <= all_timer - TIMER_ONE;
        end
        all_banks_busy <= (all_timer > TIMER_ONE);
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/sdrrs_defines.vh ----
// Purpose: Constants for the SDRAM refresh command decoder and bank scheduler.
// Assumes: 125 MHz clock; timing figures in picoseconds.
// Notes:   Cycle counts are derived from the times by rounding up.
`ifndef SDRRS_DEFINES_VH
`define SDRRS_DEFINES_VH

`define SDRRS_CLK_PERIOD_PS        8000
`define SDRRS_ALL_BANK_REFRESH_CYCLE_TIME_PS            130000
`define SDRRS_SINGLE_BANK_REFRESH_CYCLE_TIME_PS            60000
`define SDRRS_ALL_BANK_REFRESH_CYCLE_TIME_CYC           ((`SDRRS_ALL_BANK_REFRESH_CYCLE_TIME_PS + `SDRRS_CLK_PERIOD_PS - 1) / `SDRRS_CLK_PERIOD_PS)
`define SDRRS_SINGLE_BANK_REFRESH_CYCLE_TIME_CYC           ((`SDRRS_SINGLE_BANK_REFRESH_CYCLE_TIME_PS + `SDRRS_CLK_PERIOD_PS - 1) / `SDRRS_CLK_PERIOD_PS)
`define SDRRS_TIMER_W              5
`define SDRRS_BANK_W               3
`define SDRRS_NUM_BANKS            8
`define SDRRS_BANK_LAST            3'h7

`endif

// ---- test/sdrrs_refresh_properties.sv ----
// Purpose: Port timing checks. Assumes: clk_en high. Notes: Bench spaces refreshes apart.
`timescale 1ns/100ps
`default_nettype none
module sdrrs_refresh_props (
  input wire logic       clock, arst_n, chip_select_n, reset_cmd, self_refresh_exit,
  input wire logic       cmd_addr_bit0, cmd_addr_bit1, cmd_addr_bit2, cmd_addr_bit3,
  input wire logic [2:0] next_refresh_bank, refreshed_bank,
  input wire logic [7:0] bank_busy,
  input wire logic       all_banks_busy, single_bank_refresh, all_bank_refresh);
  wire clr = reset_cmd | self_refresh_exit;
  wire rf  = !chip_select_n & !cmd_addr_bit0 & !cmd_addr_bit1 & cmd_addr_bit2 & !clr;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_single_decode: assert property (single_bank_refresh == $past(rf & !cmd_addr_bit3, 3))
    else $error("single refresh pulse wrong");
  a_all_decode: assert property (all_bank_refresh == $past(rf & cmd_addr_bit3, 3))
    else $error("all refresh pulse wrong");
  a_bank_step: assert property (single_bank_refresh |-> next_refresh_bank == refreshed_bank + 3'h1)
    else $error("bank counter did not step");
  a_all_clear: assert property (all_bank_refresh |-> next_refresh_bank == 3'h0)
    else $error("all refresh kept counter");
  a_resync_clear: assert property ($past(clr, 3) |-> next_refresh_bank == 3'h0)
    else $error("resync kept counter");
  a_bank_busy: assert property (single_bank_refresh |-> bank_busy[refreshed_bank])
    else $error("refreshed bank not busy");
  a_bank_idle: assert property (single_bank_refresh |-> ##[8:9] bank_busy == 8'h00)
    else $error("bank stayed busy");
  a_all_idle: assert property (all_bank_refresh |-> all_banks_busy ##[17:18] !all_banks_busy)
    else $error("all banks busy wrong");
endmodule
bind sdrrs_refresh sdrrs_refresh_props u_sdrrs_refresh_props (.*);
`default_nettype wire

// ---- test/sdrrs_ctrl_model.sv ----
// Purpose: Controller model. Assumes: eight idle banks. Notes: Gap set by caller.
`timescale 1ns/100ps
`default_nettype none
module sdrrs_ctrl_model (
  input  wire logic       clock,
  output var  logic       chip_select_n,
  output var  logic [3:0] cmd);
  initial chip_select_n = 1'b1;
  initial cmd = 4'h0;
  task send(input logic [3:0] c, input int gap);
    @(negedge clock);
    chip_select_n = 1'b0;
    cmd = c;
    @(negedge clock);
    chip_select_n = 1'b1;
    // Deselected pins flip so a stale value is never mistaken for a command.
    cmd = ~c;
    repeat (gap) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ---- test/test_sdrrs_refresh.sv ----
// Purpose: Refresh decoder bench. Assumes: 125 MHz. Notes: Checks after each spacing gap.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,e) begin checked++; if ((a)!==(e)) begin fails++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_sdrrs_refresh;
  logic       clock = 0, arst_n = 0, rc = 0, sx = 0, cs_n, ab, sp, ap;
  logic [3:0] cmd;
  logic [2:0] nb, rb;
  logic [7:0] bb;
  int         fails = 0, checked = 0, cyc = 0;
  sdrrs_ctrl_model u_sdrrs_ctrl_model (.clock(clock), .chip_select_n(cs_n), .cmd(cmd));
  sdrrs_refresh u_sdrrs_refresh (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
    .chip_select_n(cs_n), .cmd_addr_bit0(cmd[0]), .cmd_addr_bit1(cmd[1]), .cmd_addr_bit2(cmd[2]),
    .cmd_addr_bit3(cmd[3]), .reset_cmd(rc), .self_refresh_exit(sx), .next_refresh_bank(nb),
    .bank_busy(bb), .all_banks_busy(ab), .single_bank_refresh(sp), .all_bank_refresh(ap),
    .refreshed_bank(rb));
  initial forever #4 clock = ~clock;
  task test_done;
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done;
    end
  end
  task t_round;
    for (int i = 0; i < 9; i++) begin
      u_sdrrs_ctrl_model.send(4'h4, 14);
      `CHK(rb, 3'(i))
      `CHK(bb, 8'h00)
    end
    u_sdrrs_ctrl_model.send(4'h6, 14);
    `CHK(nb, 3'h1)
    u_sdrrs_ctrl_model.send(4'hC, 6);
    `CHK(ab, 1'b1)
    repeat (18) @(negedge clock);
    `CHK(nb, 3'h0)
    `CHK(ab, 1'b0)
  endtask
  task t_sync;
    for (int j = 0; j < 2; j++) begin
      u_sdrrs_ctrl_model.send(4'h4, 14);
      {rc, sx} = j ? 2'b01 : 2'b10;
      @(negedge clock);
      {rc, sx} = 2'b00;
      repeat (4) @(negedge clock);
      `CHK(nb, 3'h0)
    end
  endtask
  initial begin
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    t_round;
    t_sync;
    test_done;
  end
endmodule
`default_nettype wire
